// [verilog/cssj_top.sv]
// configuration scheme select and test access port front end
// assumes tck from the jtag host, unrelated to clk; trst_n optional, tie high if unused
// What this block does
// - scheme selects 00 give passive serial, 10 passive parallel sync, 11 passive parallel async.
// - a jtag configuration overrides every scheme, but the select levels still set the mode that shows once it ends.
// - once in user mode, select changes do nothing.
// - tdi is captured on each rising tck edge while the tap is in shift-ir or shift-dr.
// - tdo is updated on each falling tck edge.
// - tdo is released whenever nothing is being shifted out.
// - the tap state machine samples tms and moves on each rising tck edge.
// - a low trst_n resets the boundary scan logic at once, without tck.
`timescale 1ns/100ps
`default_nettype none
`include "cssj_cfg.svh"
module cssj_top import cssj_pkg::*; #(
    parameter int DR_W = `CSSJ_DR_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scheme_select_hi,
    input wire logic scheme_select_lo,
    input wire logic reconfig_start,
    input wire logic user_mode,
    output cssj_scheme_t scheme,
    output logic [DR_W-1:0] prog_data,
    output logic prog_valid,
    input wire logic prog_ready,
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo_o,
    output logic tdo_oe
);
    // ---------------- tck domain ----------------
    cssj_tap_t tap, next_tap;
    logic [`CSSJ_IR_W-1:0] ir_sh, ir, next_ir_sh, next_ir;
    logic [DR_W-1:0] dr_sh, next_dr_sh;
    logic byp, next_byp;
    logic [DR_W-1:0] word, next_word;
    logic word_tgl, next_word_tgl;
    logic prog_sel;
    logic tdo_q, tdo_en;
    always_comb begin
        next_tap = tap;
        case (tap)
            CSSJ_TLR: next_tap = tms ? CSSJ_TLR : CSSJ_RTI;
            CSSJ_RTI: next_tap = tms ? CSSJ_SDS : CSSJ_RTI;
            CSSJ_SDS: next_tap = tms ? CSSJ_SIS : CSSJ_CDR;
            CSSJ_CDR: next_tap = tms ? CSSJ_E1D : CSSJ_SDR;
            CSSJ_SDR: next_tap = tms ? CSSJ_E1D : CSSJ_SDR;
            CSSJ_E1D: next_tap = tms ? CSSJ_UDR : CSSJ_PDR;
            CSSJ_PDR: next_tap = tms ? CSSJ_E2D : CSSJ_PDR;
            CSSJ_E2D: next_tap = tms ? CSSJ_UDR : CSSJ_SDR;
            CSSJ_UDR: next_tap = tms ? CSSJ_SDS : CSSJ_RTI;
            CSSJ_SIS: next_tap = tms ? CSSJ_TLR : CSSJ_CIR;
            CSSJ_CIR: next_tap = tms ? CSSJ_E1I : CSSJ_SIR;
            CSSJ_SIR: next_tap = tms ? CSSJ_E1I : CSSJ_SIR;
            CSSJ_E1I: next_tap = tms ? CSSJ_UIR : CSSJ_PIR;
            CSSJ_PIR: next_tap = tms ? CSSJ_E2I : CSSJ_PIR;
            CSSJ_E2I: next_tap = tms ? CSSJ_UIR : CSSJ_SIR;
            CSSJ_UIR: next_tap = tms ? CSSJ_SDS : CSSJ_RTI;
            default: next_tap = CSSJ_TLR;
        endcase
        prog_sel = (ir == `CSSJ_IR_PROGRAM);
        next_ir_sh = ir_sh;
        next_ir = ir;
        next_dr_sh = dr_sh;
        next_byp = byp;
        next_word = word;
        next_word_tgl = word_tgl;
        case (tap)
            CSSJ_TLR: next_ir = `CSSJ_IR_RESET;
            CSSJ_CIR: next_ir_sh = `CSSJ_IR_RESET;
            CSSJ_SIR: next_ir_sh = {tdi, ir_sh[`CSSJ_IR_W-1:1]};
            CSSJ_UIR: next_ir = ir_sh;
            CSSJ_CDR: begin
                next_byp = 1'b0;
                next_dr_sh = '0;
            end
            CSSJ_SDR: begin
                next_byp = tdi;
                next_dr_sh = {tdi, dr_sh[DR_W-1:1]};
            end
            CSSJ_UDR: begin
                if (prog_sel) begin
                    next_word = dr_sh;
                    next_word_tgl = ~word_tgl;
                end
            end
            default: next_ir = ir;
        endcase
    end
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tap <= CSSJ_TLR;
            ir_sh <= `CSSJ_IR_RESET;
            ir <= `CSSJ_IR_RESET;
            dr_sh <= '0;
            byp <= 1'b0;
        end else begin
            tap <= next_tap;
            ir_sh <= next_ir_sh;
            ir <= next_ir;
            dr_sh <= next_dr_sh;
            byp <= next_byp;
        end
    end
    // handoff word and toggle survive a tap reset, so no false word reaches the clk side
    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            word <= '0;
            word_tgl <= 1'b0;
        end else begin
            word <= next_word;
            word_tgl <= next_word_tgl;
        end
    end
    logic next_tdo_q, next_tdo_en;
    always_comb begin
        next_tdo_en = (tap == CSSJ_SIR) || (tap == CSSJ_SDR);
        if (tap == CSSJ_SIR) begin
            next_tdo_q = ir_sh[0];
        end else if (prog_sel) begin
            next_tdo_q = dr_sh[0];
        end else begin
            next_tdo_q = byp;
        end
    end
    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tdo_q <= 1'b0;
            tdo_en <= 1'b0;
        end else begin
            tdo_q <= next_tdo_q;
            tdo_en <= next_tdo_en;
        end
    end
    assign tdo_o = tdo_q;
    assign tdo_oe = tdo_en;
    // ---------------- clk domain ----------------
    logic [1:0] sel_s1, sel_s2;
    logic rc_s1, rc_s2, rc_d, um_s1, um_s2;
    logic tg_s1, tg_s2, tg_d;
    logic jtag_s1, jtag_s2;
    cssj_mode_t mode, next_mode;
    logic jtag_load, next_jtag_load;
    logic in_valid, in_ready;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_s1 <= 2'h0;
            sel_s2 <= 2'h0;
            rc_s1 <= 1'b0;
            rc_s2 <= 1'b0;
            rc_d <= 1'b0;
            um_s1 <= 1'b0;
            um_s2 <= 1'b0;
            tg_s1 <= 1'b0;
            tg_s2 <= 1'b0;
            tg_d <= 1'b0;
            jtag_s1 <= 1'b0;
            jtag_s2 <= 1'b0;
        end else begin
            sel_s1 <= {scheme_select_hi, scheme_select_lo};
            sel_s2 <= sel_s1;
            rc_s1 <= reconfig_start;
            rc_s2 <= rc_s1;
            rc_d <= rc_s2;
            um_s1 <= user_mode;
            um_s2 <= um_s1;
            tg_s1 <= word_tgl;
            tg_s2 <= tg_s1;
            tg_d <= tg_s2;
            jtag_s1 <= prog_sel;
            jtag_s2 <= jtag_s1;
        end
    end
    always_comb begin
        next_mode = mode;
        next_jtag_load = jtag_s2;
        // selects are sampled only at the rising edge of reconfig_start, never in user mode
        if (rc_s2 && !rc_d && !um_s2) begin
            case (sel_s2)
                `CSSJ_SEL_PS: next_mode = CSSJ_M_PS;
                `CSSJ_SEL_PPS: next_mode = CSSJ_M_PPS;
                `CSSJ_SEL_PPA: next_mode = CSSJ_M_PPA;
                default: next_mode = CSSJ_M_NONE;
            endcase
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode <= CSSJ_M_NONE;
            jtag_load <= 1'b0;
        end else begin
            mode <= next_mode;
            jtag_load <= next_jtag_load;
        end
    end
    always_comb begin
        scheme.jtag_load = jtag_load;
        scheme.passive_serial_load = !jtag_load && (mode == CSSJ_M_PS);
        scheme.passive_parallel_sync_load = !jtag_load && (mode == CSSJ_M_PPS);
        scheme.passive_parallel_async_load = !jtag_load && (mode == CSSJ_M_PPA);
    end
    // word is stable in tck domain for many clk cycles after its toggle settles
    assign in_valid = tg_s2 ^ tg_d;
    cssj_buf2 #(.W(DR_W)) u_buf (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(word),
        .out_valid(prog_valid),
        .out_ready(prog_ready),
        .out_data(prog_data)
    );
    tap_reset_five_a: assert property (@(posedge tck) disable iff (!trst_n)
        (tms [*5]) |=> (tap == CSSJ_TLR)) else $error("tap not reset after five tms highs");
    tap_shift_move_a: assert property (@(posedge tck) disable iff (!trst_n)
        (tap == CSSJ_SDR && !tms) |=> (tap == CSSJ_SDR)) else $error("shift dr left with tms low");
    tdo_release_a: assert property (@(negedge tck) disable iff (!trst_n)
        (tap != CSSJ_SIR && tap != CSSJ_SDR) |=> !tdo_oe) else $error("tdo driven while idle");
    tdo_fall_a: assert property (@(negedge tck) disable iff (!trst_n)
        (tap == CSSJ_SIR) |=> (tdo_o == $past(ir_sh[0])))
        else $error("tdo not moved on the falling edge");
    tdi_capture_a: assert property (@(posedge tck) disable iff (!trst_n)
        (tap == CSSJ_SIR) |=> (ir_sh[`CSSJ_IR_W-1] == $past(tdi))) else $error("tdi not captured");
    trst_reset_a: assert property (@(posedge clk) !trst_n |-> (tap == CSSJ_TLR && !tdo_oe))
        else $error("trst did not reset tap");
    jtag_priority_a: assert property (@(posedge clk) disable iff (!arst_n)
        jtag_load |-> !(scheme.passive_serial_load || scheme.passive_parallel_sync_load
        || scheme.passive_parallel_async_load)) else $error("passive scheme active under jtag");
    user_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        um_s2 |=> (mode == $past(mode))) else $error("mode changed in user mode");
    sel_decode_a: assert property (@(posedge clk) disable iff (!arst_n)
        (rc_s2 && !rc_d && !um_s2 && sel_s2 == 2'h2) |=> (mode == CSSJ_M_PPS))
        else $error("selects 10 not decoded to parallel sync");
    buf_refuse_a: assert property (@(posedge clk) disable iff (!arst_n)
        (prog_valid && !prog_ready) |=> prog_valid) else $error("buffered word lost");
endmodule
`default_nettype wire

// [verilog/cssj_cfg.svh]
// constants for the configuration scheme select and test access port block
// assumes inclusion by bare name from the package and the modules
`ifndef CSSJ_CFG_SVH
`define CSSJ_CFG_SVH
`define CSSJ_SEL_PS 2'h0
`define CSSJ_SEL_PPS 2'h2
`define CSSJ_SEL_PPA 2'h3
`define CSSJ_IR_W 4
`define CSSJ_IR_RESET 4'h1
`define CSSJ_IR_BYPASS 4'hf
`define CSSJ_IR_PROGRAM 4'h2
`define CSSJ_DR_W 8
`define CSSJ_SYNC_STAGES 2
`endif

// [verilog/cssj_pkg.sv]
// types for the configuration scheme select and test access port block
// assumes cssj_cfg.svh on the include path
`include "cssj_cfg.svh"
package cssj_pkg;
    typedef enum logic [15:0] {
        CSSJ_TLR = 16'h0001, CSSJ_RTI = 16'h0002, CSSJ_SDS = 16'h0004, CSSJ_CDR = 16'h0008,
        CSSJ_SDR = 16'h0010, CSSJ_E1D = 16'h0020, CSSJ_PDR = 16'h0040, CSSJ_E2D = 16'h0080,
        CSSJ_UDR = 16'h0100, CSSJ_SIS = 16'h0200, CSSJ_CIR = 16'h0400, CSSJ_SIR = 16'h0800,
        CSSJ_E1I = 16'h1000, CSSJ_PIR = 16'h2000, CSSJ_E2I = 16'h4000, CSSJ_UIR = 16'h8000
    } cssj_tap_t;
    typedef enum logic [3:0] {
        CSSJ_M_NONE = 4'h1, CSSJ_M_PS = 4'h2, CSSJ_M_PPS = 4'h4, CSSJ_M_PPA = 4'h8
    } cssj_mode_t;
    typedef struct packed {
        logic passive_serial_load;
        logic passive_parallel_sync_load;
        logic passive_parallel_async_load;
        logic jtag_load;
    } cssj_scheme_t;
    typedef struct packed {
        logic tdo_o;
        logic tdo_oe;
    } cssj_tdo_t;
endpackage

// [verilog/cssj_buf2.sv]
// two-entry buffer with valid and ready on both sides
// assumes one clock; drain side may stall at will
`timescale 1ns/100ps
`default_nettype none
module cssj_buf2 #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem [2];
    logic rd, wr;
    logic [1:0] cnt;
    logic [W-1:0] next_mem [2];
    logic rdp, wrp, next_rdp, next_wrp;
    logic [1:0] next_cnt;
    assign in_ready = (cnt != 2'h2);
    assign out_valid = (cnt != 2'h0);
    assign out_data = mem[rdp];
    always_comb begin
        wr = in_valid && in_ready;
        rd = out_valid && out_ready;
        next_mem = mem;
        if (wr) begin
            next_mem[wrp] = in_data;
        end
        next_wrp = wr ? ~wrp : wrp;
        next_rdp = rd ? ~rdp : rdp;
        next_cnt = cnt + {1'b0, wr} - {1'b0, rd};
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem[0] <= '0;
            mem[1] <= '0;
            rdp <= 1'b0;
            wrp <= 1'b0;
            cnt <= 2'h0;
        end else begin
            mem <= next_mem;
            rdp <= next_rdp;
            wrp <= next_wrp;
            cnt <= next_cnt;
        end
    end
    full_never_overflow_a: assert property (@(posedge clk) disable iff (!arst_n) cnt <= 2'h2)
        else $error("buffer count above depth");
endmodule
`default_nettype wire

// [verif/cssj_jtag_host.sv]
// jtag host model: runs tck only inside frames and shifts bits lsb first
// assumes the tap takes tms and tdi on rising tck and moves tdo on falling tck
`timescale 1ns/100ps
`default_nettype none
module cssj_jtag_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo_o,
    input wire logic tdo_oe
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // one 30 ns tck period; tms and tdi move only while tck is low
    task automatic step(input logic m, input logic d, output logic q, output logic e);
        tms = m;
        tdi = d;
        #15;
        q = tdo_o;
        e = tdo_oe;
        tck = 1'b1;
        #15;
        tck = 1'b0;
    endtask
    task automatic reset5();
        logic q;
        logic e;
        for (int i = 0; i < 5; i++) begin
            step(1'b1, 1'b1, q, e);
        end
    endtask
    // idle -> shift, n bits, update, back to idle; ok stays high if tdo was driven on every shifted bit
    task automatic shift(input logic ir, input logic [7:0] v, input int n, output logic [7:0] q, output logic ok);
        logic b;
        logic e;
        q = 8'h00;
        ok = 1'b1;
        step(1'b0, 1'b0, b, e);
        step(1'b1, 1'b0, b, e);
        if (ir) begin
            step(1'b1, 1'b0, b, e);
        end
        step(1'b0, 1'b0, b, e);
        step(1'b0, 1'b0, b, e);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, v[i], b, e);
            q[i] = b;
            ok = ok & e;
        end
        step(1'b1, 1'b0, b, e);
        step(1'b0, 1'b0, b, e);
    endtask
endmodule
`default_nettype wire

// [verif/cssj_top_tb_top.sv]
// self-checking bench for the scheme select and test access port block
// assumes the jtag host model drives tck, tms and tdi
`timescale 1ns/100ps
`default_nettype none
module cssj_top_tb_top;
    import cssj_pkg::*;
    logic clk, arst_n, sel_hi, sel_lo, reconfig, user_mode, prog_valid, prog_ready;
    logic tck, trst_n, tms, tdi, tdo_o, tdo_oe, ok;
    cssj_scheme_t scheme;
    logic [7:0] prog_data, q;
    int fails = 0;
    int comparisons = 0;
    cssj_top u_cssj_top (.clk(clk), .arst_n(arst_n), .scheme_select_hi(sel_hi), .scheme_select_lo(sel_lo),
        .reconfig_start(reconfig), .user_mode(user_mode), .scheme(scheme), .prog_data(prog_data),
        .prog_valid(prog_valid), .prog_ready(prog_ready), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
        .tdo_o(tdo_o), .tdo_oe(tdo_oe));
    cssj_jtag_host u_cssj_jtag_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // settle the selects, then pulse reconfiguration and let the answer land
    task automatic sel_go(input logic h, input logic l);
        @(posedge clk) {sel_hi, sel_lo} <= {h, l};
        repeat (4) @(posedge clk);
        reconfig <= 1'b1;
        repeat (6) @(posedge clk);
        reconfig <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic t_select();
        logic [1:0] sel [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
        logic [3:0] exp [4] = '{4'h8, 4'h4, 4'h2, 4'h0};
        for (int i = 0; i < 4; i++) begin
            sel_go(sel[i][1], sel[i][0]);
            check({4'h0, scheme}, {4'h0, exp[i]});
        end
    endtask
    task automatic t_user();
        sel_go(1'b0, 1'b0);
        @(posedge clk) user_mode <= 1'b1;
        sel_go(1'b1, 1'b1);
        check({4'h0, scheme}, 8'h08);
        @(posedge clk) user_mode <= 1'b0;
    endtask
    task automatic set_ir2();
        u_cssj_jtag_host.shift(1'b1, 8'h02, 4, q, ok);
        check(q, 8'h01);
        check({7'h0, ok}, 8'h01);
        check({7'h0, tdo_oe}, 8'h00);
        repeat (6) @(posedge clk);
        check({4'h0, scheme}, 8'h01);
    endtask
    task automatic pop(input logic [7:0] exp);
        int n;
        for (n = 0; n < 20 && prog_valid !== 1'b1; n++) @(negedge clk);
        if (prog_valid !== 1'b1) begin
            fails++;
            $display("ERROR %0t: no word offered", $time);
            results();
        end else begin
            check(prog_data, exp);
            @(posedge clk) prog_ready <= 1'b1;
            @(posedge clk) prog_ready <= 1'b0;
            @(negedge clk);
        end
    endtask
    task automatic t_jtag();
        u_cssj_jtag_host.reset5();
        set_ir2();
        sel_go(1'b1, 1'b1);
        check({4'h0, scheme}, 8'h01);
        u_cssj_jtag_host.shift(1'b0, 8'ha5, 8, q, ok);
        check(q, 8'h00);
        check({7'h0, ok}, 8'h01);
        u_cssj_jtag_host.shift(1'b0, 8'h3c, 8, q, ok);
        repeat (6) @(posedge clk);
        check({7'h0, prog_valid}, 8'h01);
        pop(8'ha5);
        pop(8'h3c);
        u_cssj_jtag_host.shift(1'b0, 8'hff, 8, q, ok);
        pop(8'hff);
        repeat (2) @(posedge clk);
        check({7'h0, prog_valid}, 8'h00);
    endtask
    task automatic t_tap_reset();
        @(posedge clk) trst_n <= 1'b0;
        repeat (2) @(posedge clk);
        check({7'h0, tdo_oe}, 8'h00);
        trst_n <= 1'b1;
        repeat (6) @(posedge clk);
        check({7'h0, scheme.jtag_load}, 8'h00);
        check({7'h0, prog_valid}, 8'h00);
        set_ir2();
        u_cssj_jtag_host.reset5();
        repeat (6) @(posedge clk);
        check({7'h0, scheme.jtag_load}, 8'h00);
    endtask
    initial begin
        {arst_n, sel_hi, sel_lo, reconfig, user_mode, prog_ready} = 6'h00;
        trst_n = 1'b1;
        // tck is idle during reset, so the tap needs a real falling edge on trst_n
        @(posedge clk) trst_n <= 1'b0;
        repeat (15) @(posedge clk);
        arst_n <= 1'b1;
        trst_n <= 1'b1;
        @(posedge clk);
        check({4'h0, scheme}, 8'h00);
        check({6'h0, prog_valid, tdo_oe}, 8'h00);
        t_select();
        t_user();
        t_jtag();
        t_tap_reset();
        results();
    end
endmodule
`default_nettype wire
